// >>> hw/exbp_pkg.sv
// Package of shared constants and types for the expansion bus port and board end
package exbp_pkg;

    // ==========================================================
    // Register map offsets (byte addresses, 16-bit spaced map)
    localparam logic [7:0] EXBP_OFS_RD_ONE    = 8'hC0;
    localparam logic [7:0] EXBP_OFS_RD_TWO    = 8'hC2;
    localparam logic [7:0] EXBP_OFS_RD_SPARE  = 8'hC4;
    localparam logic [7:0] EXBP_OFS_BUS_RESET = 8'hC6;
    localparam logic [7:0] EXBP_OFS_ADR_FIRST = 8'hC8;
    localparam logic [7:0] EXBP_OFS_ADR_SECND = 8'hCA;
    localparam logic [7:0] EXBP_OFS_ADR_THIRD = 8'hCC;
    localparam logic [7:0] EXBP_OFS_WRITE     = 8'hCE;
    // Designer's own control and status registers (AHB word offsets)
    localparam logic [7:0] EXBP_OFS_LCD_CTRL  = 8'hD0;
    localparam logic [7:0] EXBP_OFS_LCD_DATA  = 8'hD4;
    localparam logic [7:0] EXBP_OFS_STATUS    = 8'hD8;
    localparam logic [7:0] EXBP_OFS_CONFIG    = 8'hDC;

    // ==========================================================
    // Field positions
    localparam int EXBP_CFG_WIDE_BIT   = 0;  // Config: 1 = 8-bit data operations
    localparam int EXBP_LCD_RS_BIT     = 0;  // LCD ctrl: register select level
    localparam int EXBP_LCD_READ_BIT   = 1;  // LCD ctrl: 1 = display read cycle
    localparam int EXBP_ST_ATTN_BIT    = 0;  // Status: attention request level
    localparam int EXBP_ST_BUSY_BIT    = 1;  // Status: a cycle is in progress
    localparam int EXBP_ST_WIDE_BIT    = 2;  // Status: current data width

    // ==========================================================
    // Reset values
    localparam logic [7:0] EXBP_RST_BYTE   = 8'h00;
    localparam logic [2:0] EXBP_RST_OP     = 3'h0;
    localparam logic       EXBP_RST_WIDE   = 1'b0;

    // ==========================================================
    // Operation codes carried on op_select
    localparam logic [2:0] EXBP_OP_RD_ONE    = 3'h0;
    localparam logic [2:0] EXBP_OP_RD_TWO    = 3'h1;
    localparam logic [2:0] EXBP_OP_RD_SPARE  = 3'h2;
    localparam logic [2:0] EXBP_OP_BUS_RESET = 3'h3;
    localparam logic [2:0] EXBP_OP_ADR_FIRST = 3'h4;
    localparam logic [2:0] EXBP_OP_ADR_SECND = 3'h5;
    localparam logic [2:0] EXBP_OP_ADR_THIRD = 3'h6;
    localparam logic [2:0] EXBP_OP_WRITE     = 3'h7;

    // ==========================================================
    // Timing: setup, strobe and hold phases of one bus cycle
    localparam int EXBP_SETUP_NS  = 40;
    localparam int EXBP_STROBE_NS = 100;
    localparam int EXBP_HOLD_NS   = 40;
    localparam int EXBP_CLK_NS    = 20;
    localparam logic [3:0] EXBP_SETUP_CYC  = 4'((EXBP_SETUP_NS + EXBP_CLK_NS - 1) / EXBP_CLK_NS);
    localparam logic [3:0] EXBP_STROBE_CYC = 4'((EXBP_STROBE_NS + EXBP_CLK_NS - 1) / EXBP_CLK_NS);
    localparam logic [3:0] EXBP_HOLD_CYC   = 4'((EXBP_HOLD_NS + EXBP_CLK_NS - 1) / EXBP_CLK_NS);

    // ==========================================================
    // Bus cycle sequencer states
    typedef enum logic [2:0] {
        EXBP_IDLE,
        EXBP_SETUP,
        EXBP_STROBE,
        EXBP_HOLD,
        EXBP_DONE
    } exbp_state_t;

    // AHB transfer type codes
    localparam logic [1:0] EXBP_HTRANS_NONSEQ = 2'h2;

endpackage

// >>> hw/exbp_link_if.sv
// Interface carrying the shared connector lines between port and boards
`timescale 1ns/100ps
`default_nettype none
interface exbp_link_if;
    // ==========================================================
    // Display bus lines, driven by the port only
    logic       lcd_strobe;
    logic       lcd_read_strobe_n;
    logic       lcd_write_strobe_n;
    logic       lcd_reg_select;
    // ==========================================================
    // Expansion bus control, driven by the port only
    logic       expansion_strobe_n;
    logic [2:0] op_select;
    // ==========================================================
    // Shared data lines: each end has out and enable
    logic [3:0] low_data_nibble_port_o;
    logic       low_data_nibble_port_oe;
    logic [3:0] high_data_nibble_port_o;
    logic       high_data_nibble_port_oe;
    logic [3:0] low_data_nibble_brd_o;
    logic       low_data_nibble_brd_oe;
    logic [3:0] high_data_nibble_brd_o;
    logic       high_data_nibble_brd_oe;
    logic [3:0] low_data_nibble;    // Resolved wire level
    logic [3:0] high_data_nibble;
    // ==========================================================
    // Open-drain attention: board pulls low when enabled
    logic       attention_brd_oe;
    logic       attention_n;

    // Resolution: the driving end wins, undriven lines float high
    assign low_data_nibble  = low_data_nibble_port_oe  ? low_data_nibble_port_o  :
                              low_data_nibble_brd_oe   ? low_data_nibble_brd_o   : 4'hF;
    assign high_data_nibble = high_data_nibble_port_oe ? high_data_nibble_port_o :
                              high_data_nibble_brd_oe  ? high_data_nibble_brd_o  : 4'hF;
    assign attention_n      = ~attention_brd_oe;

    modport port (
        output lcd_strobe, lcd_read_strobe_n, lcd_write_strobe_n, lcd_reg_select,
        output expansion_strobe_n, op_select,
        output low_data_nibble_port_o, low_data_nibble_port_oe,
        output high_data_nibble_port_o, high_data_nibble_port_oe,
        input  low_data_nibble, high_data_nibble, attention_n
    );
    modport board (
        input  expansion_strobe_n, op_select,
        output low_data_nibble_brd_o, low_data_nibble_brd_oe,
        output high_data_nibble_brd_o, high_data_nibble_brd_oe,
        output attention_brd_oe,
        input  low_data_nibble, high_data_nibble
    );
endinterface
`default_nettype wire

// >>> hw/exbp_port.sv
// Controller-side expansion bus port with AHB-Lite register slave
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module exbp_port (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        srst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Attention request to the host
    output logic             attn_irq,
    // Connector
    exbp_link_if.port        link
);
    import exbp_pkg::*;

    // ==========================================================
    // Address phase capture
    logic        req_q;          // Data phase pending
    logic        req_wr_q;       // Pending access is a write
    logic [7:0]  req_addr_q;     // Pending byte address
    logic        ready_q;        // One-cycle answer pulse
    logic        hrdyo_q;        // Ready level shown on the bus
    logic [31:0] rdata_q;        // Registered read data
    logic        wide_q;         // Config: 8-bit data operations
    logic [1:0]  lcd_ctrl_q;     // Display select and direction
    logic        attn_s1_q;      // Attention synchroniser stages
    logic        attn_s2_q;
    logic [3:0]  lo_s1_q;        // Data line synchronisers
    logic [3:0]  lo_s2_q;
    logic [3:0]  hi_s1_q;
    logic [3:0]  hi_s2_q;
    exbp_state_t state_q;        // Sequencer state
    logic [3:0]  cnt_q;          // Phase cycle counter
    logic        cyc_lcd_q;      // Cycle targets the display bus
    logic        cyc_rd_q;       // Cycle reads the data lines
    logic [2:0]  op_q;           // Op code for the cycle
    logic [7:0]  wbyte_q;        // Byte driven during a write

    logic        addr_phase;     // Valid address phase seen
    logic        is_exp;         // Offset is one of the eight registers
    logic        is_lcd_data;    // Offset is the display data window
    logic        start_cycle;    // Begin a connector cycle

    assign addr_phase  = hsel && hready && htrans == EXBP_HTRANS_NONSEQ;
    assign is_exp      = req_addr_q[7:4] == EXBP_OFS_RD_ONE[7:4] && !req_addr_q[0];
    assign is_lcd_data = req_addr_q == EXBP_OFS_LCD_DATA;
    // Writes to read-only and reads of write-only registers still run a cycle of that code
    // The answered request is still pending in the answer cycle; ready_q keeps it from running twice
    assign start_cycle = req_q && !ready_q && state_q == EXBP_IDLE && (is_exp || is_lcd_data);

    // Capture each address phase; the data phase waits on the sequencer
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            req_q      <= 1'b0;
            req_wr_q   <= 1'b0;
            req_addr_q <= EXBP_RST_BYTE;
        end else if (addr_phase) begin
            req_q      <= 1'b1;
            req_wr_q   <= hwrite;
            req_addr_q <= haddr;
        end else if (ready_q) begin
            req_q      <= 1'b0;
        end
    end

    // Synchronise the pins before any logic reads them
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            attn_s1_q <= 1'b1;
            attn_s2_q <= 1'b1;
            lo_s1_q   <= 4'hF;
            lo_s2_q   <= 4'hF;
            hi_s1_q   <= 4'hF;
            hi_s2_q   <= 4'hF;
        end else begin
            attn_s1_q <= link.attention_n;
            attn_s2_q <= attn_s1_q;
            lo_s1_q   <= link.low_data_nibble;
            lo_s2_q   <= lo_s1_q;
            hi_s1_q   <= link.high_data_nibble;
            hi_s2_q   <= hi_s1_q;
        end
    end

    // A low attention level is a live request, not latched
    always_ff @(posedge sys_clk) begin
        if (srst) attn_irq <= 1'b0;
        else      attn_irq <= ~attn_s2_q;
    end

    // Host-owned configuration registers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wide_q     <= EXBP_RST_WIDE;
            lcd_ctrl_q <= 2'h0;
        end else if (req_q && req_wr_q && ready_q) begin
            if (req_addr_q == EXBP_OFS_CONFIG)   wide_q     <= hwdata[EXBP_CFG_WIDE_BIT];
            if (req_addr_q == EXBP_OFS_LCD_CTRL) lcd_ctrl_q <= hwdata[1:0];
        end
    end

    // ==========================================================
    // Connector cycle sequencer: setup, strobe, hold, done
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_q   <= EXBP_IDLE;
            cnt_q     <= 4'h0;
            cyc_lcd_q <= 1'b0;
            cyc_rd_q  <= 1'b0;
            op_q      <= EXBP_RST_OP;
            wbyte_q   <= EXBP_RST_BYTE;
        end else begin
            unique case (state_q)
                EXBP_IDLE: begin
                    if (start_cycle) begin
                        // Op and data load only while strobes are idle
                        state_q   <= EXBP_SETUP;
                        cnt_q     <= EXBP_SETUP_CYC;
                        cyc_lcd_q <= is_lcd_data;
                        op_q      <= req_addr_q[3:1];
                        cyc_rd_q  <= is_lcd_data ? lcd_ctrl_q[EXBP_LCD_READ_BIT] : !req_addr_q[3];
                        wbyte_q   <= hwdata[7:0];
                    end
                end
                EXBP_SETUP: begin
                    if (cnt_q == 4'h1) begin
                        state_q <= EXBP_STROBE;
                        cnt_q   <= EXBP_STROBE_CYC;
                    end else cnt_q <= cnt_q - 4'h1;
                end
                EXBP_STROBE: begin
                    if (cnt_q == 4'h1) begin
                        state_q <= EXBP_HOLD;
                        cnt_q   <= EXBP_HOLD_CYC;
                    end else cnt_q <= cnt_q - 4'h1;
                end
                EXBP_HOLD: begin
                    if (cnt_q == 4'h1) state_q <= EXBP_DONE;
                    else               cnt_q   <= cnt_q - 4'h1;
                end
                EXBP_DONE: state_q <= EXBP_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Connector outputs, all registered
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            link.expansion_strobe_n       <= 1'b1;
            link.op_select                <= EXBP_RST_OP;
            link.lcd_strobe               <= 1'b0;
            link.lcd_read_strobe_n        <= 1'b1;
            link.lcd_write_strobe_n       <= 1'b1;
            link.lcd_reg_select           <= 1'b0;
            link.low_data_nibble_port_oe  <= 1'b0;
            link.high_data_nibble_port_oe <= 1'b0;
            link.low_data_nibble_port_o   <= 4'h0;
            link.high_data_nibble_port_o  <= 4'h0;
        end else begin
            // Strobes active in the strobe phase only
            link.expansion_strobe_n <= !(state_q == EXBP_STROBE && !cyc_lcd_q);
            link.lcd_strobe         <= state_q == EXBP_STROBE && cyc_lcd_q;
            link.lcd_read_strobe_n  <= !(state_q == EXBP_STROBE && cyc_lcd_q && cyc_rd_q);
            link.lcd_write_strobe_n <= !(state_q == EXBP_STROBE && cyc_lcd_q && !cyc_rd_q);
            // Select lines change only outside the strobe window
            if (state_q == EXBP_SETUP) begin
                link.op_select      <= op_q;
                link.lcd_reg_select <= lcd_ctrl_q[EXBP_LCD_RS_BIT];
            end
            // Data lines driven only during our own write-type cycle; shared by both buses
            link.low_data_nibble_port_oe  <= (state_q == EXBP_SETUP || state_q == EXBP_STROBE ||
                                              state_q == EXBP_HOLD) && !cyc_rd_q;
            link.high_data_nibble_port_oe <= (state_q == EXBP_SETUP || state_q == EXBP_STROBE ||
                                              state_q == EXBP_HOLD) && !cyc_rd_q &&
                                             (wide_q || cyc_lcd_q);
            link.low_data_nibble_port_o   <= wbyte_q[3:0];
            link.high_data_nibble_port_o  <= wbyte_q[7:4];
        end
    end

    // ==========================================================
    // AHB response; the data phase ends with the connector cycle, or at once for the local registers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ready_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ready_q <= 1'b0;
            if (state_q == EXBP_DONE) begin
                ready_q <= 1'b1;
                // Narrow bus reads see only the low nibble; the high nibble reads as ones
                rdata_q <= {24'h0000_00, (wide_q || cyc_lcd_q) ? hi_s2_q : 4'hF, lo_s2_q};
                if (!cyc_rd_q) rdata_q <= 32'h0000_0000;
            end else if (req_q && !ready_q && state_q == EXBP_IDLE && !start_cycle) begin
                ready_q <= 1'b1;
                unique case (req_addr_q)
                    EXBP_OFS_CONFIG: rdata_q <= {31'h0000_0000, wide_q};
                    EXBP_OFS_LCD_CTRL: rdata_q <= {30'h0000_0000, lcd_ctrl_q};
                    EXBP_OFS_STATUS: rdata_q <= {29'h0000_0000, wide_q, 1'b0, ~attn_s2_q};
                    default: rdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Bus ready level from a flop: low from each address phase until its answer
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            hrdyo_q <= 1'b1;
        end else if (addr_phase) begin
            hrdyo_q <= 1'b0;
        end else if (state_q == EXBP_DONE || (req_q && !ready_q && state_q == EXBP_IDLE && !start_cycle)) begin
            hrdyo_q <= 1'b1;
        end
    end

    assign hreadyout = hrdyo_q;
    assign hrdata    = rdata_q;
    assign hresp     = 1'b0;
endmodule
`default_nettype wire

// >>> hw/exbp_board.sv
// Expansion board end: staged address latches and a small register
`timescale 1ns/100ps
`default_nettype none
module exbp_board (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        srst,
    // Board jumpers and user side
    input  wire logic [7:0]  my_addr_first,
    input  wire logic [7:0]  my_addr_second,
    input  wire logic [7:0]  my_addr_third,
    input  wire logic [7:0]  rd_value,
    input  wire logic        attn_req,
    output logic [7:0]       wr_value,
    output logic             wr_pulse,
    output logic             selected,
    output logic             wide_mode,
    // Connector
    exbp_link_if.board       link
);
    import exbp_pkg::*;

    // ==========================================================
    // Pin synchronisers
    logic       stb_s1_q, stb_s2_q, stb_d_q;
    logic [2:0] op_s1_q, op_s2_q;
    logic [3:0] lo_s1_q, lo_s2_q, hi_s1_q, hi_s2_q;
    logic [2:0] latch_q;        // Chained selection latches
    logic       fall;           // Strobe falling edge
    logic       wide_next;      // Mode from first byte
    logic [7:0] byte_in;        // Bus byte as seen

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            stb_s1_q <= 1'b1;
            stb_s2_q <= 1'b1;
            stb_d_q  <= 1'b1;
            op_s1_q  <= 3'h0;
            op_s2_q  <= 3'h0;
            lo_s1_q  <= 4'h0;
            lo_s2_q  <= 4'h0;
            hi_s1_q  <= 4'h0;
            hi_s2_q  <= 4'h0;
        end else begin
            stb_s1_q <= link.expansion_strobe_n;
            stb_s2_q <= stb_s1_q;
            stb_d_q  <= stb_s2_q;
            op_s1_q  <= link.op_select;
            op_s2_q  <= op_s1_q;
            lo_s1_q  <= link.low_data_nibble;
            lo_s2_q  <= lo_s1_q;
            hi_s1_q  <= link.high_data_nibble;
            hi_s2_q  <= hi_s1_q;
        end
    end

    assign fall      = stb_d_q && !stb_s2_q;
    // Low four bits of the first byte pick the category; 11xx is byte wide
    assign wide_next = lo_s2_q[3:2] == 2'b11;
    assign byte_in   = wide_mode ? {hi_s2_q, lo_s2_q} : {4'h0, lo_s2_q};

    // Staged address latches, cleared by a bus reset
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            latch_q   <= 3'h0;
            wide_mode <= 1'b0;
        end else if (fall) begin
            unique case (op_s2_q)
                EXBP_OP_BUS_RESET: latch_q <= 3'h0;
                EXBP_OP_ADR_FIRST: begin
                    wide_mode  <= wide_next;
                    latch_q    <= {2'b00, (wide_next ? {hi_s2_q, lo_s2_q} : {4'h0, lo_s2_q})
                                          == my_addr_first};
                end
                EXBP_OP_ADR_SECND: latch_q[1] <= latch_q[0] && byte_in == my_addr_second;
                EXBP_OP_ADR_THIRD: latch_q[2] <= latch_q[1] && byte_in == my_addr_third;
                default: ;
            endcase
        end
    end
    assign selected = latch_q[2];

    // Write data captured while selected
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wr_value <= 8'h00;
            wr_pulse <= 1'b0;
        end else begin
            wr_pulse <= fall && selected && op_s2_q == EXBP_OP_WRITE;
            if (fall && selected && op_s2_q == EXBP_OP_WRITE) wr_value <= byte_in;
        end
    end

    // Drive read data while strobe low; bit 0 low marks presence
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            link.low_data_nibble_brd_oe  <= 1'b0;
            link.high_data_nibble_brd_oe <= 1'b0;
            link.low_data_nibble_brd_o   <= 4'h0;
            link.high_data_nibble_brd_o  <= 4'h0;
            link.attention_brd_oe        <= 1'b0;
        end else begin
            link.low_data_nibble_brd_oe  <= selected && !stb_s2_q && !op_s2_q[2]
                                            && op_s2_q != EXBP_OP_BUS_RESET;
            link.high_data_nibble_brd_oe <= selected && !stb_s2_q && !op_s2_q[2]
                                            && op_s2_q != EXBP_OP_BUS_RESET && wide_mode;
            link.low_data_nibble_brd_o   <= {rd_value[3:1], 1'b0};
            link.high_data_nibble_brd_o  <= rd_value[7:4];
            link.attention_brd_oe        <= attn_req;
        end
    end
endmodule
`default_nettype wire

// >>> dv/exbp_link_chk.sv
// Checker of the connector lines between port and board
`timescale 1ns/100ps
`default_nettype none
module exbp_link_chk (
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       srst,
    // Display bus
    input wire logic       lcd_strobe,
    input wire logic       lcd_read_strobe_n,
    input wire logic       lcd_write_strobe_n,
    input wire logic       lcd_reg_select,
    // Expansion bus
    input wire logic       expansion_strobe_n,
    input wire logic [2:0] op_select,
    input wire logic [3:0] low_data_nibble_port_o,
    input wire logic       low_data_nibble_port_oe
);
    // ==========================================
    // Assertions, all in the one clock domain
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    strobe_width_a: assert property ($fell(expansion_strobe_n) |->
        !expansion_strobe_n [*5] ##1 expansion_strobe_n) else $error("strobe width wrong");
    op_stable_a: assert property (!expansion_strobe_n && !$fell(expansion_strobe_n) |->
        $stable(op_select)) else $error("op code moved under strobe");
    wdata_stable_a: assert property (!expansion_strobe_n && !$fell(expansion_strobe_n)
        && low_data_nibble_port_oe |-> $stable(low_data_nibble_port_o)) else $error("data moved");
    read_release_a: assert property (!expansion_strobe_n && !op_select[2] |->
        !low_data_nibble_port_oe) else $error("port drives during read");
    write_drive_a: assert property (!expansion_strobe_n && op_select[2] |->
        low_data_nibble_port_oe) else $error("port idle during write");
    lcd_pair_a: assert property ($rose(lcd_strobe) |->
        lcd_read_strobe_n != lcd_write_strobe_n) else $error("display strobes wrong");
    bus_apart_a: assert property (!expansion_strobe_n |->
        lcd_read_strobe_n && lcd_write_strobe_n && !lcd_strobe) else $error("buses overlap");
    rs_stable_a: assert property (lcd_strobe && !$rose(lcd_strobe) |->
        $stable(lcd_reg_select)) else $error("register select moved");
endmodule
`default_nettype wire

// >>> dv/test_expansion_bus_port.sv
// Bench: port and board joined over the connector
`timescale 1ns/100ps
`default_nettype none
module test_expansion_bus_port;
    import exbp_pkg::*;
    // ==========================================
    // Stimulus and score
    logic        sys_clk = 1'b0;
    logic        srst = 1'b1;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [7:0]  haddr = 8'h00;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata, rd;
    logic        hreadyout, hresp, attn_irq, wr_pulse, selected, wide_mode;
    logic [7:0]  adr1 = 8'h00, adr2 = 8'h00, adr3 = 8'h00, rd_value = 8'h00, wr_value, d;
    logic        attn_req = 1'b0;
    logic [31:0] exp_q[$], act_q[$];
    int          failures = 0;
    int          checks = 0;
    int          pulses = 0;
    exbp_link_if link ();
    always #10 sys_clk = ~sys_clk;
    exbp_port i_exbp_port (.sys_clk(sys_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .attn_irq(attn_irq), .link(link));
    exbp_board i_exbp_board (.sys_clk(sys_clk), .srst(srst), .my_addr_first(adr1), .my_addr_second(adr2),
        .my_addr_third(adr3), .rd_value(rd_value), .attn_req(attn_req), .wr_value(wr_value),
        .wr_pulse(wr_pulse), .selected(selected), .wide_mode(wide_mode), .link(link));
    exbp_link_chk i_exbp_link_chk (.sys_clk(sys_clk), .srst(srst), .lcd_strobe(link.lcd_strobe),
        .lcd_read_strobe_n(link.lcd_read_strobe_n), .lcd_write_strobe_n(link.lcd_write_strobe_n),
        .lcd_reg_select(link.lcd_reg_select), .expansion_strobe_n(link.expansion_strobe_n),
        .op_select(link.op_select), .low_data_nibble_port_o(link.low_data_nibble_port_o),
        .low_data_nibble_port_oe(link.low_data_nibble_port_oe));
    // ==========================================
    // One single AHB transfer; waits as long as the slave stalls
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= EXBP_HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        rd = hrdata;
    endtask
    // Read with a noted expectation; only the low byte carries data, bit 8 shows an error response
    task automatic rdx(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back({24'h0, e});
        xfer(1'b0, a, 32'h0000_0000);
        act_q.push_back({23'h0, hresp, rd[7:0]});
    endtask
    // Count board write strobes; each host write to the write register of a selected board makes exactly one
    always @(posedge sys_clk) begin
        if (wr_pulse === 1'b1) pulses++;
    end
    // Note an expectation on a board output
    task automatic chk(input logic [7:0] act, input logic [7:0] e);
        exp_q.push_back({24'h0, e});
        act_q.push_back({24'h0, act});
    endtask
    // Three address stages in their order
    task automatic stages(input logic [7:0] x1, input logic [7:0] x2, input logic [7:0] x3);
        xfer(1'b1, EXBP_OFS_ADR_FIRST, {24'h0, x1});
        xfer(1'b1, EXBP_OFS_ADR_SECND, {24'h0, x2});
        xfer(1'b1, EXBP_OFS_ADR_THIRD, {24'h0, x3});
    endtask
    task automatic conclude();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Compare each result with the oldest note
    initial begin
        forever begin
            wait (act_q.size() > 0);
            checks++;
            if (act_q[0] !== exp_q[0]) begin
                failures++;
                $display("ERROR %0t: got %h expected %h", $time, act_q[0], exp_q[0]);
            end
            void'(act_q.pop_front());
            void'(exp_q.pop_front());
        end
    end
    // Watchdog: a hang counts as a mismatch
    initial begin
        repeat (6000) @(posedge sys_clk);
        failures++;
        conclude();
    end
    // ==========================================
    // Main sequence
    initial begin
        void'($urandom(32'had61e4bb));
        repeat (8) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        rdx(EXBP_OFS_CONFIG, 8'h00);
        for (int i = 0; i < 3; i++) rdx(EXBP_OFS_RD_ONE + 8'(2 * i), 8'hFF);
        // Narrow board: category below 0011 means 4-bit stages
        adr1 <= 8'($urandom % 3);
        adr2 <= 8'($urandom % 16);
        adr3 <= 8'($urandom % 16);
        rd_value <= 8'($urandom);
        d = 8'($urandom);
        @(posedge sys_clk);
        stages(adr1, adr2, adr3);
        chk({6'h00, wide_mode, selected}, 8'h01);
        xfer(1'b1, EXBP_OFS_WRITE, {24'h0, d});
        chk({4'h0, wr_value[3:0]}, {4'h0, d[3:0]});
        rdx(EXBP_OFS_RD_ONE, {4'hF, rd_value[3:1], 1'b0});
        xfer(1'b0, EXBP_OFS_BUS_RESET, 32'h0000_0000);
        chk({7'h0, selected}, 8'h00);
        rdx(EXBP_OFS_RD_ONE, 8'hFF);
        stages(adr1, adr2 ^ 8'h01, adr3);
        chk({7'h0, selected}, 8'h00);
        // Wide board: category 1101 means three 8-bit stages
        xfer(1'b1, EXBP_OFS_CONFIG, 32'h0000_0001);
        adr1 <= {4'($urandom), 4'hD};
        adr2 <= 8'($urandom);
        adr3 <= 8'($urandom);
        @(posedge sys_clk);
        stages(adr1, adr2, adr3);
        chk({6'h00, wide_mode, selected}, 8'h03);
        xfer(1'b1, EXBP_OFS_WRITE, {24'h0, ~d});
        chk(wr_value, ~d);
        rdx(EXBP_OFS_RD_ONE, {rd_value[7:1], 1'b0});
        // Attention raised then withdrawn
        attn_req <= 1'b1;
        repeat (8) @(posedge sys_clk);
        rdx(EXBP_OFS_STATUS, 8'h05);
        chk({7'h0, attn_irq}, 8'h01);
        attn_req <= 1'b0;
        repeat (8) @(posedge sys_clk);
        chk({7'h0, attn_irq}, 8'h00);
        // Display write then read cycle
        xfer(1'b1, EXBP_OFS_LCD_CTRL, 32'h0000_0001);
        xfer(1'b1, EXBP_OFS_LCD_DATA, {24'h0, d});
        xfer(1'b1, EXBP_OFS_LCD_CTRL, 32'h0000_0002);
        xfer(1'b1, EXBP_OFS_LCD_DATA, 32'h0000_0000);
        xfer(1'b1, 8'hE0, 32'h0000_00A5);
        rdx(8'hE0, 8'h00);
        repeat (4) @(posedge sys_clk);
        chk(8'(pulses), 8'h02);
        conclude();
    end
endmodule
`default_nettype wire
